/* File: hw/osc_clock_select.sv */
// Internal oscillator block: sources, dividers, switchover, pins
// Behaviour
// [RL1] Reset strap picks boot clock: 110 is 1 MHz, 000 is 32 MHz
// [RL2] Software write of new source select switches clock while running
// [RL3] Internal mode frees input pin; output pin is GPIO or clock out
// [RL4] Output pin role set only by clock-out enable configuration bit
// [RL5] Two oscillators: high rate up to 32 MHz, low rate 31 kHz
// [RL6] High oscillator rate follows software frequency select field
// [RL7] High oscillator output divided 1:1 up to 1:512 by divider field
// [RL8] Fixed 500 kHz and 31.25 kHz derived, adapting to every setting
// [RL9] Fixed mid clocks never drive system clock, only peripherals
// [RL10] Doubler fed by high oscillator at 8, 12 or 16 MHz only
// [RL11] Software trim value shifts high oscillator around its setting
// [RL12] Switch only once new source is stable, with no short pulses
module osc_clock_select #(
    parameter int unsigned STABLE_TICKS = 8
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Configuration words
    input  wire logic [2:0]  reset_oscillator_select_i,
    input  wire logic        clock_out_pin_enable_i,
    // Oscillator pins
    input  wire logic        osc_out_gpio_i,
    input  wire logic        osc_out_gpio_oe_i,
    output logic             osc_in_gpio_o,
    output logic             osc_out_is_clk_o,
    output logic             osc_out_pin_o,
    output logic             osc_out_oe_o,
    output logic             internal_oscillator_mode_o,
    // Clock enables
    output logic             sys_clk_en_o,
    output logic             mf_500k_en_o,
    output logic             mf_31k_en_o
);

    if (STABLE_TICKS < 1 || STABLE_TICKS > 255) begin
        $error("STABLE_TICKS out of range");
    end

    localparam logic [7:0] STAB_LAST = 8'(STABLE_TICKS - 1);
    localparam logic [31:0] LF_INC =
        osc_pkg::nco_inc(osc_pkg::LF_KHZ);

    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_RUN  = 3'b010,
        ST_WAIT = 3'b100
    } state_e;

    // ------------------------------------------------------------
    // Configuration synchroniser
    // ------------------------------------------------------------
    logic [3:0] cfg_meta_reg;
    logic [3:0] cfg_sync_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_meta_reg <= 4'h0;
            cfg_sync_reg <= 4'h0;
        end else begin
            cfg_meta_reg <= {clock_out_pin_enable_i,
                             reset_oscillator_select_i};
            cfg_sync_reg <= cfg_meta_reg;
        end
    end

    logic [2:0] boot_src;
    logic [2:0] boot_frq;
    logic       clkout_en;

    always_comb begin
        case (cfg_sync_reg[2:0])
            osc_pkg::SRC_HF_PLL: boot_src = osc_pkg::SRC_HF_PLL; // RL1
            osc_pkg::SRC_LF:     boot_src = osc_pkg::SRC_LF;
            default:             boot_src = osc_pkg::SRC_HF;     // RL1
        endcase
        boot_frq = (cfg_sync_reg[2:0] == osc_pkg::SRC_HF_PLL) ?
                   osc_pkg::FRQ_16M : osc_pkg::FRQ_1M;           // RL1
        clkout_en = cfg_sync_reg[3];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    state_e      state_reg;
    logic [1:0]  boot_cnt_reg;
    logic [2:0]  cur_src_reg;
    logic [7:0]  stab_cnt_reg;
    logic [2:0]  new_oscillator_select_reg;
    logic [3:0]  clock_divider_select_reg;
    logic [3:0]  div_wr;
    logic [2:0]  frq_reg;
    logic [5:0]  trim_reg;
    logic        boot_load;
    logic        bus_req;
    logic        bus_wr;
    logic        pll_ok;

    assign boot_load = (state_reg == ST_BOOT) &&
                       (boot_cnt_reg == osc_pkg::BOOT_CYCLES);
    assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr    = bus_req && wb_we_i && wb_sel_i[0];
    assign div_wr    = wb_dat_i[osc_pkg::CTRL_CLK_DIV_LSB +: 4];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            new_oscillator_select_reg <= osc_pkg::SRC_HF;
            clock_divider_select_reg  <= 4'h0;
            frq_reg                   <= osc_pkg::FRQ_1M;
            trim_reg                  <= 6'h00;
        end else if (boot_load) begin
            new_oscillator_select_reg <= boot_src;               // RL1
            frq_reg                   <= boot_frq;
        end else if (bus_wr) begin
            case (wb_adr_i)
                osc_pkg::ADR_CTRL: begin
                    new_oscillator_select_reg <=
                        wb_dat_i[osc_pkg::CTRL_NEW_OSC_LSB +: 3]; // RL2
                    clock_divider_select_reg <=
                        (div_wr > osc_pkg::CLK_DIV_MAX) ?
                        osc_pkg::CLK_DIV_MAX : div_wr;           // RL7
                end
                osc_pkg::ADR_FREQ: frq_reg  <= wb_dat_i[2:0];   // RL6
                osc_pkg::ADR_TRIM: trim_reg <= wb_dat_i[5:0];   // RL11
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Oscillators as phase accumulators
    // ------------------------------------------------------------
    logic [31:0]        base_inc;
    logic signed [29:0] trim_delta;
    logic [31:0]        hf_inc;
    logic [31:0]        hf_acc_reg;
    logic [31:0]        pll_acc_reg;
    logic [31:0]        lf_acc_reg;
    logic               hf_tick_reg;
    logic               pll_tick_reg;
    logic               lf_tick_reg;

    always_comb begin
        case (frq_reg)                                           // RL6
            3'h0:    base_inc = osc_pkg::nco_inc(1000);
            3'h1:    base_inc = osc_pkg::nco_inc(2000);
            3'h2:    base_inc = osc_pkg::nco_inc(4000);
            3'h3:    base_inc = osc_pkg::nco_inc(8000);
            3'h4:    base_inc = osc_pkg::nco_inc(12000);
            3'h5:    base_inc = osc_pkg::nco_inc(16000);
            3'h6:    base_inc = osc_pkg::nco_inc(32000);
            default: base_inc = osc_pkg::nco_inc(1000);
        endcase
    end

    assign trim_delta = $signed({1'b0,
                        base_inc[31:osc_pkg::TRIM_SHIFT]}) *
                        $signed(trim_reg);                       // RL11
    assign hf_inc = base_inc + 32'(trim_delta);                  // RL11
    assign pll_ok = (frq_reg == osc_pkg::FRQ_8M)  ||
                    (frq_reg == osc_pkg::FRQ_12M) ||
                    (frq_reg == osc_pkg::FRQ_16M);               // RL10

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hf_acc_reg  <= 32'h0000_0000;
            hf_tick_reg <= 1'b0;
        end else begin
            {hf_tick_reg, hf_acc_reg} <=
                {1'b0, hf_acc_reg} + {1'b0, hf_inc};             // RL5
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !pll_ok) begin
            pll_acc_reg  <= 32'h0000_0000;
            pll_tick_reg <= 1'b0;
        end else begin
            {pll_tick_reg, pll_acc_reg} <=
                {1'b0, pll_acc_reg} + {hf_inc, 1'b0};            // RL10
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lf_acc_reg  <= 32'h0000_0000;
            lf_tick_reg <= 1'b0;
        end else begin
            {lf_tick_reg, lf_acc_reg} <=
                {1'b0, lf_acc_reg} + {1'b0, LF_INC};             // RL5
        end
    end

    // Source mux; mid clocks have no path here
    function automatic logic src_tick(input logic [2:0] src);
        case (src)                                               // RL9
            osc_pkg::SRC_HF_PLL: return pll_tick_reg;
            osc_pkg::SRC_LF:     return lf_tick_reg;
            default:             return hf_tick_reg;
        endcase
    endfunction

    function automatic logic src_valid(input logic [2:0] src);
        return (src == osc_pkg::SRC_HF_PLL) ||
               (src == osc_pkg::SRC_LF) || (src == osc_pkg::SRC_HF);
    endfunction

    // ------------------------------------------------------------
    // Switchover control
    // ------------------------------------------------------------
    logic new_tick;
    logic cur_tick;
    logic new_ready;
    logic switch_now;

    // Function reads tick flops, so evaluate where they are sensed
    always_comb begin
        new_tick = src_tick(new_oscillator_select_reg);
        cur_tick = src_tick(cur_src_reg);
    end

    assign new_ready  = (new_oscillator_select_reg != osc_pkg::SRC_HF_PLL) ||
                        pll_ok;
    assign switch_now = (state_reg == ST_WAIT) && new_tick &&
                        new_ready && (stab_cnt_reg == STAB_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg    <= ST_BOOT;
            boot_cnt_reg <= 2'h0;
            cur_src_reg  <= osc_pkg::SRC_HF;
            stab_cnt_reg <= 8'h00;
        end else begin
            case (state_reg)
                ST_BOOT: begin
                    boot_cnt_reg <= boot_cnt_reg + 2'h1;
                    if (boot_load) begin
                        cur_src_reg <= boot_src;                 // RL1
                        state_reg   <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    stab_cnt_reg <= 8'h00;
                    if (new_oscillator_select_reg != cur_src_reg &&
                        src_valid(new_oscillator_select_reg)) begin
                        state_reg <= ST_WAIT;                    // RL2
                    end
                end
                ST_WAIT: begin
                    if (new_oscillator_select_reg == cur_src_reg ||
                        !src_valid(new_oscillator_select_reg)) begin
                        state_reg <= ST_RUN;
                    end else if (switch_now) begin
                        cur_src_reg <= new_oscillator_select_reg; // RL12
                        state_reg   <= ST_RUN;
                    end else if (new_tick && new_ready) begin
                        stab_cnt_reg <= stab_cnt_reg + 8'h01;    // RL12
                    end
                end
                default: state_reg <= ST_BOOT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // System clock post-divider
    // ------------------------------------------------------------
    logic [9:0] div_cnt_reg;
    logic [9:0] div_term;
    logic       div_hit;

    assign div_term = 10'((11'h001 << clock_divider_select_reg) -
                          11'h001);                              // RL7
    assign div_hit  = cur_tick && (div_cnt_reg >= div_term);

    always_ff @(posedge clk_i) begin
        if (rst_i || state_reg == ST_BOOT || switch_now) begin
            div_cnt_reg  <= 10'h000;                             // RL12
            sys_clk_en_o <= 1'b0;
        end else begin
            sys_clk_en_o <= div_hit;                             // RL7
            if (div_hit) begin
                div_cnt_reg <= 10'h000;
            end else if (cur_tick) begin
                div_cnt_reg <= div_cnt_reg + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Fixed mid-frequency clocks
    // ------------------------------------------------------------
    logic [5:0] mf_cnt_reg;
    logic [5:0] mf_term;
    logic [3:0] mf_lo_reg;
    logic       mf_hit;

    // Seven bits hold twice the top rate without wrapping
    assign mf_term = 6'(({1'b0, osc_pkg::hf_mhz(frq_reg)} *
                     7'(1000 / osc_pkg::MF_HI_KHZ)) - 7'h01);   // RL8
    assign mf_hit  = hf_tick_reg && (mf_cnt_reg >= mf_term);     // RL8

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mf_cnt_reg   <= 6'h00;
            mf_lo_reg    <= 4'h0;
            mf_500k_en_o <= 1'b0;
            mf_31k_en_o  <= 1'b0;
        end else begin
            mf_500k_en_o <= mf_hit;                              // RL8
            mf_31k_en_o  <= mf_hit &&
                            (mf_lo_reg == osc_pkg::MF_LO_TERM);  // RL8
            if (mf_hit) begin
                mf_cnt_reg <= 6'h00;
                mf_lo_reg  <= mf_lo_reg + 4'h1;
            end else if (hf_tick_reg) begin
                mf_cnt_reg <= mf_cnt_reg + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Oscillator pins
    // ------------------------------------------------------------
    logic [1:0] co_cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            co_cnt_reg                 <= 2'h0;
            osc_in_gpio_o              <= 1'b0;
            internal_oscillator_mode_o <= 1'b0;
            osc_out_is_clk_o           <= 1'b0;
            osc_out_pin_o              <= 1'b0;
            osc_out_oe_o               <= 1'b0;
        end else begin
            if (sys_clk_en_o) begin
                co_cnt_reg <= co_cnt_reg + 2'h1;
            end
            internal_oscillator_mode_o <= (state_reg != ST_BOOT);
            osc_in_gpio_o    <= (state_reg != ST_BOOT);          // RL3
            osc_out_is_clk_o <= clkout_en;                       // RL4
            osc_out_pin_o    <= clkout_en ? co_cnt_reg[1] :
                                osc_out_gpio_i;                  // RL3
            osc_out_oe_o     <= clkout_en | osc_out_gpio_oe_i;   // RL4
        end
    end

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------
    osc_pkg::status_s stat;

    always_comb begin
        stat         = '0;
        stat.pll_ok  = pll_ok;
        stat.busy    = (state_reg != ST_RUN);
        stat.clock_divider_select = clock_divider_select_reg;
        stat.src     = cur_src_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req) begin
                case (wb_adr_i)
                    osc_pkg::ADR_CTRL: wb_dat_o <= {24'h00_0000,
                                           clock_divider_select_reg, 1'b0,
                                           new_oscillator_select_reg};
                    osc_pkg::ADR_FREQ: wb_dat_o <= {29'h0, frq_reg};
                    osc_pkg::ADR_TRIM: wb_dat_o <= {26'h0, trim_reg};
                    osc_pkg::ADR_STAT: wb_dat_o <= stat;
                    default:           wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    boot_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
        boot_load |=> cur_src_reg == $past(boot_src)) // RL1
        else $error("boot source not taken from strap");

    run_switch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_wr && wb_adr_i == osc_pkg::ADR_CTRL && state_reg == ST_RUN
        && wb_dat_i[2:0] == osc_pkg::SRC_LF && cur_src_reg !=
        osc_pkg::SRC_LF |=> ##1 state_reg == ST_WAIT) // RL2
        else $error("run-time source write not acted on");

    pin_role_a: assert property (@(posedge clk_i) disable iff (rst_i)
        osc_out_is_clk_o |-> osc_out_oe_o && $past(clkout_en)) // RL4
        else $error("output pin role not from enable bit");

    in_pin_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_RUN |=> osc_in_gpio_o) // RL3
        else $error("input pin not released");

    div_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        div_cnt_reg <= 10'h1FF) // RL7
        else $error("post-divider count beyond range");

    mf_nest_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mf_31k_en_o |-> mf_500k_en_o) // RL8
        else $error("low mid clock not aligned to high mid clock");

    sys_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
        src_valid(cur_src_reg)) // RL9
        else $error("system clock on a non-oscillator source");

    pll_input_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pll_tick_reg |-> $past(pll_ok)) // RL10
        else $error("doubler ran on unsupported input");

    clean_switch_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $changed(cur_src_reg) && !$past(boot_load) |->
        $past(stab_cnt_reg) == STAB_LAST && !sys_clk_en_o) // RL12
        else $error("switch before source stable or mid pulse");

endmodule

/* File: hw/osc_pkg.sv */
// Constants and types of the internal oscillator clock selector
package osc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ     = 200000;
    localparam int unsigned LF_KHZ      = 31;
    localparam int unsigned MF_HI_KHZ   = 500;
    localparam logic [3:0]  MF_LO_TERM  = 4'hF;
    localparam logic [1:0]  BOOT_CYCLES = 2'h3;
    localparam int unsigned TRIM_SHIFT  = 9;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_FREQ = 8'h04;
    localparam logic [7:0] ADR_TRIM = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0C;
    localparam int unsigned CTRL_NEW_OSC_LSB = 0;
    localparam int unsigned CTRL_CLK_DIV_LSB = 4;
    localparam logic [3:0]  CLK_DIV_MAX      = 4'h9;

    // ------------------------------------------------------------
    // Source and frequency codes
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_HF_PLL = 3'h0;
    localparam logic [2:0] SRC_LF     = 3'h5;
    localparam logic [2:0] SRC_HF     = 3'h6;
    localparam logic [2:0] FRQ_1M     = 3'h0;
    localparam logic [2:0] FRQ_8M     = 3'h3;
    localparam logic [2:0] FRQ_12M    = 3'h4;
    localparam logic [2:0] FRQ_16M    = 3'h5;
    localparam logic [2:0] FRQ_32M    = 3'h6;

    typedef struct packed {
        logic [21:0] rsvd_hi;
        logic        pll_ok;
        logic        busy;
        logic [3:0]  clock_divider_select;
        logic        rsvd_lo;
        logic [2:0]  src;
    } status_s;

    // Phase increment of a 32-bit accumulator for a rate in kHz
    function automatic logic [31:0] nco_inc(input int unsigned khz);
        logic [63:0] t;
        t = 64'(khz) << 32;
        t = t / 64'(CLK_KHZ);
        return t[31:0];
    endfunction

    // Oscillator rate in MHz per frequency code
    function automatic logic [5:0] hf_mhz(input logic [2:0] code);
        case (code)
            3'h0:    return 6'h01;
            3'h1:    return 6'h02;
            3'h2:    return 6'h04;
            3'h3:    return 6'h08;
            3'h4:    return 6'h0C;
            3'h5:    return 6'h10;
            3'h6:    return 6'h20;
            default: return 6'h01;
        endcase
    endfunction

endpackage

/* File: testbench/clk_consumer_model.sv */
// Core and peripheral side: counts the clock enables it receives
module clk_consumer_model (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Enables from the selector
    input  wire logic sys_en_i,
    input  wire logic mf_hi_en_i,
    input  wire logic mf_lo_en_i,
    // Running counts
    output int        sys_cnt_o,
    output int        mf_cnt_o,
    output int        fault_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Core takes only the system enable, timers only the mid enables
    always @(posedge clk_i) begin
        if (rst_i) begin
            sys_cnt_o   <= 0;
            mf_cnt_o    <= 0;
            fault_cnt_o <= 0;
        end else begin
            sys_cnt_o <= sys_cnt_o + int'(sys_en_i);
            mf_cnt_o  <= mf_cnt_o + int'(mf_hi_en_i);
            // Slow mid tick must sit on a fast mid tick
            if (mf_lo_en_i && !mf_hi_en_i) begin
                fault_cnt_o <= fault_cnt_o + 1;
            end
        end
    end
endmodule

/* File: testbench/internal_osc_clock_select_tb_top.sv */
// Self-checking bench of the internal oscillator clock selector
module internal_osc_clock_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rdat;
    logic        ack;
    logic [2:0]  strap = 3'h6;
    logic        cko = 1'b0;
    logic        gpio = 1'b0;
    logic        gpio_oe = 1'b0;
    logic        in_free, is_clk, pin, pin_oe, int_mode;
    logic        sys_en, mf_hi, mf_lo;
    int          sys_cnt, mf_cnt, fault_cnt;
    int          err_total = 0;
    int          cmp_count = 0;
    int          s, m;

    always #2.5 clk = ~clk;

    osc_clock_select #(.STABLE_TICKS(2)) u_osc_clock_select (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack),
        .reset_oscillator_select_i(strap), .clock_out_pin_enable_i(cko),
        .osc_out_gpio_i(gpio), .osc_out_gpio_oe_i(gpio_oe),
        .osc_in_gpio_o(in_free), .osc_out_is_clk_o(is_clk),
        .osc_out_pin_o(pin), .osc_out_oe_o(pin_oe),
        .internal_oscillator_mode_o(int_mode), .sys_clk_en_o(sys_en),
        .mf_500k_en_o(mf_hi), .mf_31k_en_o(mf_lo));

    clk_consumer_model u_clk_consumer_model (
        .clk_i(clk), .rst_i(rst), .sys_en_i(sys_en), .mf_hi_en_i(mf_hi),
        .mf_lo_en_i(mf_lo), .sys_cnt_o(sys_cnt), .mf_cnt_o(mf_cnt),
        .fault_cnt_o(fault_cnt));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task automatic rng(input int v, input int lo, input int hi);
        chk(32'(v >= lo && v <= hi), 32'h1);
    endtask

    // Classic cycle; entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            results();
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic win(input int n);
        s = sys_cnt;
        m = mf_cnt;
        repeat (n) @(posedge clk);
        s = sys_cnt - s;
        m = mf_cnt - m;
    endtask

    task automatic wait_src(input logic [2:0] src);
        int n;
        n = 0;
        do begin
            repeat (100) @(posedge clk);
            wb(1'b0, osc_pkg::ADR_STAT, 32'h0);
            n++;
        end while (rdat[2:0] !== src && n < 400);
        if (n >= 400) begin
            err_total++;
            results();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_boot();
        wb(1'b0, osc_pkg::ADR_STAT, 32'h0);
        chk(32'(rdat[2:0]), 32'(osc_pkg::SRC_HF));
        chk(32'(rdat[7:4]), 32'h0);
        wb(1'b0, osc_pkg::ADR_FREQ, 32'h0);
        chk(32'(rdat[2:0]), 32'(osc_pkg::FRQ_1M));
        chk(32'({in_free, int_mode}), 32'h3);
        wb(1'b1, 8'h10, 32'hFF);
        wb(1'b0, 8'h10, 32'h0);
        chk(rdat, 32'h0);
        $display("test boot done");
    endtask

    task automatic t_pins();
        int   n;
        logic p;
        gpio <= 1'b1;
        gpio_oe <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'({is_clk, pin, pin_oe}), 32'h3);
        gpio <= 1'b0;
        gpio_oe <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'({is_clk, pin, pin_oe}), 32'h0);
        cko <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'({is_clk, pin_oe}), 32'h3);
        // Clock out at a quarter of the 1 MHz system clock toggles every 400 cycles
        n = 0;
        p = pin;
        repeat (1000) begin
            @(posedge clk);
            n += int'(pin != p);
            p = pin;
        end
        rng(n, 2, 3);
        $display("test pins done");
    endtask

    task automatic t_rates();
        win(4000);
        rng(s, 19, 21);
        rng(m, 9, 11);
        wb(1'b1, osc_pkg::ADR_FREQ, 32'(osc_pkg::FRQ_32M));
        win(4000);
        rng(s, 638, 642);
        rng(m, 9, 11);
        wb(1'b1, osc_pkg::ADR_CTRL, 32'h26);
        win(4000);
        rng(s, 158, 162);
        wb(1'b1, osc_pkg::ADR_CTRL, 32'hF6);
        wb(1'b0, osc_pkg::ADR_STAT, 32'h0);
        chk(32'(rdat[7:4]), 32'(osc_pkg::CLK_DIV_MAX));
        wb(1'b1, osc_pkg::ADR_CTRL, 32'h06);
        $display("test rates done");
    endtask

    task automatic t_switch();
        wb(1'b1, osc_pkg::ADR_FREQ, 32'(osc_pkg::FRQ_1M));
        wb(1'b1, osc_pkg::ADR_CTRL, 32'(osc_pkg::SRC_LF));
        wait_src(osc_pkg::SRC_LF);
        win(13000);
        rng(s, 1, 3);
        wb(1'b1, osc_pkg::ADR_CTRL, 32'(osc_pkg::SRC_HF_PLL));
        repeat (300) @(posedge clk);
        wb(1'b0, osc_pkg::ADR_STAT, 32'h0);
        chk(32'(rdat[9:8]), 32'h1);
        chk(32'(rdat[2:0]), 32'(osc_pkg::SRC_LF));
        wb(1'b1, osc_pkg::ADR_FREQ, 32'(osc_pkg::FRQ_16M));
        wait_src(osc_pkg::SRC_HF_PLL);
        chk(32'(rdat[9:8]), 32'h2);
        win(4000);
        rng(s, 638, 642);
        wb(1'b1, osc_pkg::ADR_TRIM, 32'h1F);
        win(4000);
        rng(s, 676, 682);
        $display("test switch done");
    endtask

    task automatic t_reboot();
        rst <= 1'b1;
        strap <= 3'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (30) @(posedge clk);
        wb(1'b0, osc_pkg::ADR_STAT, 32'h0);
        chk(32'(rdat[2:0]), 32'(osc_pkg::SRC_HF_PLL));
        win(4000);
        rng(s, 638, 642);
        chk(32'(fault_cnt), 32'h0);
        $display("test reboot done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        t_boot();
        t_pins();
        t_rates();
        t_switch();
        t_reboot();
        results();
    end
endmodule
